/* File: verilog/lbc_pkg.sv */
package lbc_pkg;

  // ==========================================
  // bus states and phases
  typedef enum logic [1:0] {ST_IDLE, ST_STATUS, ST_CMD, ST_HOLD} lbc_state_e;
  localparam logic PH_ONE = 1'b0;
  localparam logic PH_TWO = 1'b1;

  // ==========================================
  // prefetch queue
  localparam int QUEUE_BYTES = 6;
  localparam int LVL_W = 3;
  localparam logic [LVL_W-1:0] FETCH_ROOM = 3'h2;
  localparam logic [LVL_W-1:0] WORD_BYTES = 3'h2;
  localparam logic [LVL_W-1:0] BYTE_BYTES = 3'h1;

  // ==========================================
  // pin synchroniser slots
  localparam int SY_HOLD = 0;
  localparam int SY_COMMAND_DELAY_IN = 1;
  localparam int SY_SYNC_READY_IN = 2;
  localparam int SY_ASYNC_READY_IN = 3;
  localparam int SY_SGATE = 4;
  localparam int SY_AGATE = 5;
  localparam int SY_N = 6;
  localparam logic [SY_N-1:0] SY_RST = 6'h3e;

  // ==========================================
  // register port
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_STAT = 8'h04;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_PF_EN = 0;
  localparam int STAT_HOLD = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_ST = 4;
  localparam int STAT_LVL = 8;

endpackage

/* File: verilog/lbc_top.sv */
// Operation
// - each bus state lasts one processor clock of two system clocks
// - address strobe gives one system clock of address hold
// - command delay sampled each clock after status; command active once low
// - command delay never moves strobe, enable or direction
// - status goes inactive after status state; command state repeats until ready
// - ready marks last command state; both sides end together
// - sync ready sampled at end of phase one of each command state
// - async ready sampled at start of each command state, resolved one clock, then forwarded
// - each ready has an active low gate; either gated ready ends cycle
// - direction low for reads, high around and between writes
// - write data driven from phase two of status state
// - write data held one system clock past last command state
// - data floats in phase two after write end; never between writes
// - hold during write: finish, one idle state, then hold
// - lock for interrupt acknowledge, exchange, descriptors and lock prefix
// - locked series: lock drops after first command of next-to-last cycle
// - acknowledge cycle lock drops after its first command state
// - prefetch only on idle bus with two free queue bytes
// - word prefetches, but byte fetch after transfer to odd address
// - prefetch stops when control transfer or halt enters queue
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module lbc_top
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic xfer_req,
  input wire logic xfer_write,
  input wire logic xfer_lock,
  input wire logic xfer_lock_more,
  input wire logic xfer_inta,
  input wire logic [1:0] code_take,
  input wire logic branch_go,
  input wire logic branch_odd,
  input wire logic fetch_stop,
  input wire logic hold_req,
  input wire logic command_delay_in,
  input wire logic sync_ready_in_b,
  input wire logic async_ready_in_b,
  input wire logic sync_ready_gate_b,
  input wire logic async_ready_gate_b,
  output logic status_b,
  output logic addr_strobe,
  output logic command_b,
  output logic transceiver_enable,
  output logic transceiver_direction,
  output logic data_oe_b,
  output logic lock_b,
  output logic hold_acknowledge,
  output logic code_fetch,
  output logic byte_fetch,
  output logic xfer_ack,
  output logic cycle_done,
  output logic proc_phase
);

  // ==========================================
  // pin synchronisers
  logic [SY_N-1:0] sy_raw;
  logic [SY_N-1:0] sy_m_q;
  logic [SY_N-1:0] sy_s_q;
  assign sy_raw = {async_ready_gate_b, sync_ready_gate_b, async_ready_in_b,
                   sync_ready_in_b, command_delay_in, hold_req};

  genvar g;
  generate
    for (g = 0; g < SY_N; g++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          sy_m_q[g] <= SY_RST[g];
          sy_s_q[g] <= SY_RST[g];
        end
        else
        begin
          sy_m_q[g] <= sy_raw[g];
          sy_s_q[g] <= sy_m_q[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // state and cycle attributes
  lbc_state_e st_q, st_d;
  logic phase_q;
  logic rdy_q;
  logic async_ready_in_samp_q;
  logic cmd_on_q, cmd_on_d;
  logic first_tc_q;
  logic lock_q, lock_d;
  logic cyc_wr_q, cyc_code_q, cyc_byte_q, cyc_inta_q, cyc_more_q, cyc_drop_q;
  logic wr_tail_q;
  logic pf_en_q, pf_stop_q, pf_odd_q;
  logic [LVL_W-1:0] lvl_q, lvl_d;

  logic hold_s, command_delay_in_s, sync_ready_in_on, async_ready_in_on;
  logic ph_end, p1_end, hold_ok, cyc_end, pf_go, any_go, start;
  logic take_core, wr_d, drive_d, tail_d, pf_odd_w;
  logic [LVL_W-1:0] free_b, take_n, add_n;

  assign hold_s = sy_s_q[SY_HOLD];
  assign command_delay_in_s = sy_s_q[SY_COMMAND_DELAY_IN];
  assign sync_ready_in_on = !sy_s_q[SY_SYNC_READY_IN] && !sy_s_q[SY_SGATE];
  assign async_ready_in_on = !sy_s_q[SY_ASYNC_READY_IN] && !sy_s_q[SY_AGATE];
  assign ph_end = (phase_q == PH_TWO);
  assign p1_end = (phase_q == PH_ONE);
  assign hold_ok = hold_s && !lock_q;
  assign cyc_end = (st_q == ST_CMD) && ph_end && rdy_q;
  // bytes landing at this edge already count, or a chained fetch overruns the queue
  assign free_b = LVL_W'(QUEUE_BYTES) - lvl_q - add_n;
  // core transfers outrank code fetches
  assign pf_go = pf_en_q && !pf_stop_q && !xfer_req && (free_b >= FETCH_ROOM);
  assign any_go = xfer_req || pf_go;
  assign start = ph_end && (st_d == ST_STATUS);
  assign take_core = start && xfer_req;
  assign wr_d = start ? (xfer_req && xfer_write) : cyc_wr_q;
  assign tail_d = cyc_end && cyc_wr_q;
  // odd target lasts for one fetch only, also when the next fetch is chained
  assign pf_odd_w = pf_odd_q && !(cyc_end && cyc_code_q);

  always_comb
  begin
    st_d = st_q;
    if (ph_end)
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (hold_ok)
            st_d = ST_HOLD;
          else if (any_go)
            st_d = ST_STATUS;
        end
        ST_STATUS: st_d = ST_CMD;
        ST_CMD:
        begin
          if (rdy_q)
          begin
            // a write lends one idle state for data hold
            if (hold_ok)
              st_d = cyc_wr_q ? ST_IDLE : ST_HOLD;
            else if (any_go)
              st_d = ST_STATUS;
            else
              st_d = ST_IDLE;
          end
        end
        ST_HOLD:
        begin
          if (!hold_s)
            st_d = ST_IDLE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // command once delay input low; no resampling after activation
  assign cmd_on_d = (st_d == ST_CMD) && (cmd_on_q || !command_delay_in_s);

  always_comb
  begin
    lock_d = lock_q;
    if (start)
      lock_d = take_core && (xfer_lock || xfer_inta);
    else if (ph_end && (st_q == ST_CMD) && first_tc_q && cyc_drop_q)
      lock_d = 1'b0;
    else if (cyc_end && !cyc_more_q)
      lock_d = 1'b0;
  end

  // data pins driven from status phase two through one clock past the end
  assign drive_d = wr_d && (((st_d == ST_STATUS) && !phase_q) || (st_d == ST_CMD));

  always_comb
  begin
    take_n = (LVL_W'(code_take) > lvl_q) ? lvl_q : LVL_W'(code_take);
    add_n = '0;
    if (cyc_end && cyc_code_q)
      add_n = cyc_byte_q ? BYTE_BYTES : WORD_BYTES;
    lvl_d = lvl_q - take_n + add_n;
    if (branch_go)
      lvl_d = '0;
  end

  // ==========================================
  // sequencing
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= ST_IDLE;
      phase_q <= PH_ONE;
      rdy_q <= 1'b0;
      async_ready_in_samp_q <= 1'b0;
      cmd_on_q <= 1'b0;
      first_tc_q <= 1'b0;
      lock_q <= 1'b0;
      wr_tail_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      phase_q <= !phase_q;
      cmd_on_q <= cmd_on_d;
      lock_q <= lock_d;
      wr_tail_q <= tail_d;
      if (ph_end)
      begin
        async_ready_in_samp_q <= (st_d == ST_CMD) && async_ready_in_on;
        first_tc_q <= (st_q == ST_STATUS);
      end
      if (ph_end)
        rdy_q <= 1'b0;
      else if (p1_end && (st_q == ST_CMD))
        rdy_q <= sync_ready_in_on || async_ready_in_samp_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cyc_wr_q <= 1'b0;
      cyc_code_q <= 1'b0;
      cyc_byte_q <= 1'b0;
      cyc_inta_q <= 1'b0;
      cyc_more_q <= 1'b0;
      cyc_drop_q <= 1'b0;
    end
    else if (start)
    begin
      cyc_wr_q <= wr_d;
      cyc_code_q <= !xfer_req;
      cyc_byte_q <= !xfer_req && pf_odd_w;
      cyc_inta_q <= xfer_req && xfer_inta;
      cyc_more_q <= xfer_req && xfer_lock && xfer_lock_more && !xfer_inta;
      cyc_drop_q <= xfer_req && (xfer_inta || !xfer_lock_more);
    end
    else if (branch_go)
      cyc_code_q <= 1'b0;
  end

  // ==========================================
  // prefetch queue
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lvl_q <= '0;
      pf_stop_q <= 1'b0;
      pf_odd_q <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      if (branch_go)
      begin
        pf_stop_q <= 1'b0;
        pf_odd_q <= branch_odd;
      end
      else
      begin
        if (fetch_stop)
          pf_stop_q <= 1'b1;
        if (cyc_end && cyc_code_q)
          pf_odd_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // registered pin outputs
  logic status_b_q, ale_q, command_b_q, ten_q, tdir_q, doe_b_q, lock_b_q, hold_acknowledge_q;
  logic code_q, byte_q, ack_q, done_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      status_b_q <= 1'b1;
      ale_q <= 1'b0;
      command_b_q <= 1'b1;
      ten_q <= 1'b0;
      tdir_q <= 1'b1;
      doe_b_q <= 1'b1;
      lock_b_q <= 1'b1;
      hold_acknowledge_q <= 1'b0;
      code_q <= 1'b0;
      byte_q <= 1'b0;
      ack_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      status_b_q <= (st_d != ST_STATUS);
      ale_q <= (st_d == ST_STATUS) && !phase_q;
      command_b_q <= !cmd_on_d;
      ten_q <= drive_d || tail_d || (!wr_d && (st_d == ST_CMD));
      tdir_q <= !(!wr_d && ((st_d == ST_STATUS) || (st_d == ST_CMD)));
      doe_b_q <= !(drive_d || tail_d);
      lock_b_q <= !lock_d;
      hold_acknowledge_q <= (st_d == ST_HOLD);
      if (start)
      begin
        code_q <= !xfer_req;
        byte_q <= !xfer_req && pf_odd_w;
      end
      ack_q <= take_core;
      done_q <= cyc_end;
    end
  end

  assign status_b = status_b_q;
  assign addr_strobe = ale_q;
  assign command_b = command_b_q;
  assign transceiver_enable = ten_q;
  assign transceiver_direction = tdir_q;
  assign data_oe_b = doe_b_q;
  assign lock_b = lock_b_q;
  assign hold_acknowledge = hold_acknowledge_q;
  assign code_fetch = code_q;
  assign byte_fetch = byte_q;
  assign xfer_ack = ack_q;
  assign cycle_done = done_q;
  assign proc_phase = phase_q;

  // ==========================================
  // register port; read data only in the cycle after the strobe
  logic [DW-1:0] rdata_q, stat_w, rd_mux;
  assign stat_w = (DW'(hold_acknowledge_q) << STAT_HOLD) | (DW'(lock_q) << STAT_LOCK)
                | (DW'(pf_stop_q) << STAT_STOP) | (DW'(st_q) << STAT_ST) | (DW'(lvl_q) << STAT_LVL);
  assign rd_mux = (reg_addr == REG_CTRL) ? (DW'(pf_en_q) << CTRL_PF_EN)
                : (reg_addr == REG_STAT) ? stat_w : '0;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pf_en_q <= CTRL_RST[CTRL_PF_EN];
      rdata_q <= '0;
    end
    else
    begin
      if (reg_wr && (reg_addr == REG_CTRL))
        pf_en_q <= reg_wdata[CTRL_PF_EN];
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_state_on_phase; $changed(st_q) |-> $past(phase_q) == PH_TWO; endproperty
  a_state_on_phase: assert property (p_state_on_phase) else $error("state moved mid processor clock");
  property p_ale; ale_q |-> (!status_b_q && !$past(status_b_q)) ##1 (!ale_q && status_b_q); endproperty
  a_ale: assert property (p_ale) else $error("strobe not in status phase two");
  property p_cmd; $fell(command_b_q) |-> !$past(command_delay_in_s); endproperty
  a_cmd: assert property (p_cmd) else $error("command while delay high");
  property p_status; $fell(status_b_q) |-> ##2 status_b_q; endproperty
  a_status: assert property (p_status) else $error("status beyond status state");
  property p_end; cyc_end |=> st_q != ST_CMD; endproperty
  a_end: assert property (p_end) else $error("cycle not ended on ready");
  property p_sync; (st_q == ST_CMD) && p1_end && sync_ready_in_on |=> rdy_q; endproperty
  a_sync: assert property (p_sync) else $error("sync ready lost");
  property p_dir; (st_q == ST_CMD) && cyc_wr_q |-> tdir_q; endproperty
  a_dir: assert property (p_dir) else $error("direction low in write");
  property p_drive; $fell(doe_b_q) |-> ale_q; endproperty
  a_drive: assert property (p_drive) else $error("write drive too early");
  property p_tail; cyc_end && cyc_wr_q |=> !doe_b_q ##1 (!doe_b_q == (st_q == ST_STATUS && cyc_wr_q)); endproperty
  a_tail: assert property (p_tail) else $error("write data release wrong");
  property p_hold; cyc_end && cyc_wr_q |=> !hold_acknowledge_q [*2]; endproperty
  a_hold: assert property (p_hold) else $error("no idle before hold");
  property p_inta; ph_end && (st_q == ST_CMD) && first_tc_q && cyc_inta_q |=> lock_b_q; endproperty
  a_inta: assert property (p_inta) else $error("acknowledge lock held");

endmodule // lbc_top

/* File: dv/lbc_far_model.sv */
`timescale 1ns/1ps
module lbc_far_model
  import lbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic status_b,
  input wire logic cycle_done,
  input wire logic async_mode,
  input wire logic [2:0] waits,
  output logic sync_ready_in_b,
  output logic async_ready_in_b,
  output logic sync_ready_gate_b,
  output logic async_ready_gate_b
);
  // ==========================================
  // responder wait counter
  logic [3:0] cnt_q;
  logic busy_q;
  logic rdy;
  // zero waits keeps sync ready low all along, like a fast memory; async ready stays high
  // ready of the ending cycle must not leak into a chained one
  assign rdy = (waits == 3'h0) || (busy_q && !cycle_done && cnt_q >= {waits, 1'b0});
  always_ff @(posedge clk)
  begin
    if (!rst_b || cycle_done)
      busy_q <= 1'b0;
    else if (!status_b)
      busy_q <= 1'b1;
    cnt_q <= (busy_q && status_b) ? cnt_q + 4'h1 : 4'h0;
  end
  // ==========================================
  // ready pins
  assign sync_ready_gate_b = async_mode;
  assign async_ready_gate_b = !async_mode;
  assign sync_ready_in_b = !rdy;
  // async ready stays high while status shows
  assign async_ready_in_b = !(rdy && status_b && waits != 3'h0);
endmodule // lbc_far_model

/* File: dv/lbc_top_tb_top.sv */
`timescale 1ns/1ps
module lbc_top_tb_top
  import lbc_pkg::*;
;
  // ==========================================
  // signals
  logic clk, rst_b, reg_wr, reg_rd, xfer_req, xfer_write, xfer_lock, xfer_lock_more, xfer_inta;
  logic branch_go, branch_odd, fetch_stop, hold_req, command_delay_in, async_mode;
  logic sync_ready_in_b, async_ready_in_b, sync_ready_gate_b, async_ready_gate_b;
  logic status_b, addr_strobe, command_b, transceiver_enable, transceiver_direction, data_oe_b;
  logic lock_b, hold_acknowledge, code_fetch, byte_fetch, xfer_ack, cycle_done, proc_phase;
  logic [1:0] code_take;
  logic [2:0] waits;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rd_v;
  logic lk_s [0:63];
  logic oe_s [0:63];
  int n_errors, checks_done, n_st, n_as, n_rd, len, nc, nb, t;

  lbc_top lbc_top_i (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_lock(xfer_lock),
    .xfer_lock_more(xfer_lock_more), .xfer_inta(xfer_inta), .code_take(code_take), .branch_go(branch_go),
    .branch_odd(branch_odd), .fetch_stop(fetch_stop), .hold_req(hold_req), .command_delay_in(command_delay_in),
    .sync_ready_in_b(sync_ready_in_b), .async_ready_in_b(async_ready_in_b),
    .sync_ready_gate_b(sync_ready_gate_b), .async_ready_gate_b(async_ready_gate_b),
    .status_b(status_b), .addr_strobe(addr_strobe), .command_b(command_b),
    .transceiver_enable(transceiver_enable), .transceiver_direction(transceiver_direction),
    .data_oe_b(data_oe_b), .lock_b(lock_b), .hold_acknowledge(hold_acknowledge), .code_fetch(code_fetch),
    .byte_fetch(byte_fetch), .xfer_ack(xfer_ack), .cycle_done(cycle_done), .proc_phase(proc_phase)
  );
  lbc_far_model lbc_far_model_i (
    .clk(clk), .rst_b(rst_b), .status_b(status_b), .cycle_done(cycle_done), .async_mode(async_mode),
    .waits(waits), .sync_ready_in_b(sync_ready_in_b), .async_ready_in_b(async_ready_in_b),
    .sync_ready_gate_b(sync_ready_gate_b), .async_ready_gate_b(async_ready_gate_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================
  // helpers
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [AW-1:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_v = reg_rdata;
  endtask

  // one core cycle; keep leaves the request up for a chained cycle
  task automatic bus(input logic w, lk, lm, ia, keep, input logic [2:0] wt);
    if (xfer_req !== 1'b1)
    begin
      @(posedge clk);
      {xfer_req, xfer_write, xfer_lock, xfer_lock_more, xfer_inta, waits} <= {1'b1, w, lk, lm, ia, wt};
    end
    t = 0;
    while (xfer_ack !== 1'b1 && t < 50)
    begin
      @(negedge clk);
      t++;
    end
    {len, n_st, n_as, n_rd} = '0;
    // sample first: a chained call still sees the cycle_done of the one before
    do
    begin
      lk_s[len] = lock_b;
      oe_s[len] = data_oe_b;
      n_st += int'(status_b === 1'b0);
      n_as += int'(addr_strobe === 1'b1);
      n_rd += int'(transceiver_direction === 1'b0);
      @(posedge clk);
      xfer_req <= keep;
      @(negedge clk);
      len++;
    end while (cycle_done !== 1'b1 && len < 60);
    chk(t < 50 && len < 60, "cycle hung");
  endtask

  task automatic obs(input int n);
    {nc, nb} = '0;
    repeat (n)
    begin
      @(negedge clk);
      nc += int'(status_b === 1'b0 && code_fetch === 1'b1);
      nb += int'(status_b === 1'b0 && code_fetch === 1'b1 && byte_fetch === 1'b1);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    rd_reg(REG_CTRL);
    chk(rd_v === CTRL_RST, "ctrl reset");
    @(negedge clk);
    chk(reg_rdata === 32'h0000_0000, "read data held past its cycle");
    wr_reg(8'h08, 32'h0000_0000);
    rd_reg(8'h08);
    chk(rd_v === 32'h0000_0000, "unmapped read");
    rd_reg(REG_CTRL);
    chk(rd_v === CTRL_RST, "unmapped write hit ctrl");
    // prefetch off so core cycles own the bus
    wr_reg(REG_CTRL, 32'h0000_0000);
    rd_reg(REG_CTRL);
    chk(rd_v === 32'h0000_0000, "ctrl write");
    repeat (30) @(posedge clk);
  endtask

  task automatic t_read();
    bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    chk(n_st == 2 && len == 4, "read no-wait shape");
    chk(n_as == 1, "strobe width");
    chk(n_rd > 0, "read direction");
    chk(proc_phase === PH_ONE, "phase at cycle end");
    bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
    chk(len > 4 && len % 2 == 0, "wait states");
    @(posedge clk);
    async_mode <= 1'b1;
    bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
    chk(len > 4 && len % 2 == 0, "async ready");
    @(posedge clk);
    async_mode <= 1'b0;
  endtask

  task automatic t_write();
    bus(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    chk(oe_s[0] === 1'b1 && oe_s[1] === 1'b0, "write drive start");
    chk(data_oe_b === 1'b0, "write hold");
    bus(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    chk(oe_s[0] === 1'b0 && oe_s[1] === 1'b0, "write-write float");
    chk(n_rd == 0 && transceiver_direction === 1'b1, "write direction");
    chk(data_oe_b === 1'b0, "write hold");
    @(negedge clk);
    chk(data_oe_b === 1'b1, "write-idle float");
  endtask

  task automatic t_delay();
    @(posedge clk);
    command_delay_in <= 1'b1;
    fork
      bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7);
      begin
        @(posedge xfer_ack);
        repeat (3) @(negedge clk);
        chk(transceiver_enable === 1'b1, "enable moved");
        repeat (2) @(negedge clk);
        chk(command_b === 1'b1, "command not delayed");
        @(posedge clk);
        command_delay_in <= 1'b0;
        repeat (5) @(negedge clk);
        chk(command_b === 1'b0, "command not started");
      end
    join
  endtask

  task automatic t_hold();
    fork
      bus(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
      begin
        @(posedge xfer_ack);
        @(posedge clk);
        hold_req <= 1'b1;
      end
    join
    t = 0;
    while (hold_acknowledge !== 1'b1 && t < 20)
    begin
      @(negedge clk);
      t++;
    end
    chk(t == 2, "idle before hold");
    @(posedge clk);
    hold_req <= 1'b0;
    repeat (10) @(negedge clk);
    chk(hold_acknowledge === 1'b0, "hold not left");
  endtask

  task automatic t_lock();
    bus(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h2);
    chk(lk_s[1] === 1'b0 && lk_s[5] === 1'b0, "lock first");
    bus(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
    chk(lk_s[3] === 1'b0 && lk_s[4] === 1'b1, "lock next-to-last");
    bus(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
    chk(lk_s[1] === 1'b1, "lock last");
    bus(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
    chk(lk_s[3] === 1'b0 && lk_s[4] === 1'b1, "acknowledge lock");
  endtask

  task automatic t_fetch();
    wr_reg(REG_CTRL, 32'h0000_0001);
    // the queue filled after reset; flush it to an even target
    @(posedge clk);
    {branch_go, branch_odd} <= 2'h2;
    @(posedge clk);
    {branch_go, branch_odd} <= 2'h0;
    obs(80);
    rd_reg(REG_STAT);
    chk(nc > 0 && nb == 0 && rd_v[10:8] === 3'h6, "word fill");
    @(posedge clk);
    {branch_go, branch_odd} <= 2'h3;
    @(posedge clk);
    {branch_go, branch_odd} <= 2'h0;
    obs(80);
    rd_reg(REG_STAT);
    chk(nb > 0 && rd_v[10:8] === 3'h5, "odd branch fill");
    @(posedge clk);
    {fetch_stop, code_take} <= 3'h6;
    @(posedge clk);
    {fetch_stop, code_take} <= 3'h0;
    obs(40);
    rd_reg(REG_STAT);
    chk(nc == 0 && rd_v[STAT_STOP] === 1'b1 && rd_v[10:8] === 3'h3, "fetch stop");
  endtask

  // ==========================================
  // sequence and watchdog
  initial
  begin
    {reg_wr, reg_rd, xfer_req, xfer_write, xfer_lock, xfer_lock_more, xfer_inta, branch_go, branch_odd,
      fetch_stop, hold_req, command_delay_in, async_mode, rst_b, code_take, waits, reg_addr, reg_wdata} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk);
    t_regs();
    t_read();
    t_write();
    t_delay();
    t_hold();
    t_lock();
    t_fetch();
    complete_run();
  end

  initial
  begin
    #2_000_000;
    n_errors++;
    complete_run();
  end
endmodule // lbc_top_tb_top
